//--- verilog/tcs_pkg.sv
/*
 * Shared constants for the timer/counter with shared prescaler: register
 * offsets, option field positions, reset values and phase timing.
 * Assumes one 10 MHz oscillator clock; four of its cycles make one
 * instruction cycle.
 */
package tcs_pkg;
    localparam int unsigned TCS_ADDR_W = 8;
    localparam int unsigned TCS_DATA_W = 8;
    localparam logic [TCS_ADDR_W-1:0] TCS_OFF_COUNT = 8'h01;
    localparam logic [TCS_ADDR_W-1:0] TCS_OFF_OPTION = 8'h10;
    localparam logic [TCS_DATA_W-1:0] TCS_OPTION_RESET = 8'hff;
    localparam logic [TCS_DATA_W-1:0] TCS_COUNT_RESET = 8'h00;
    localparam int unsigned TCS_BIT_CLOCK_SOURCE = 5;
    localparam int unsigned TCS_BIT_SOURCE_EDGE = 4;
    localparam int unsigned TCS_BIT_PRESCALER_ASSIGN = 3;
    localparam int unsigned TCS_RATIO_LSB = 0;
    localparam int unsigned TCS_RATIO_W = 3;
    localparam int unsigned TCS_PRESC_W = 8;
    // Phases per instruction cycle and the inhibit span after a count write
    localparam int unsigned TCS_PHASES = 4;
    localparam logic [1:0] TCS_PHASE_Q2 = 2'h1;
    localparam logic [1:0] TCS_PHASE_Q4 = 2'h3;
    localparam logic [1:0] TCS_WRITE_INHIBIT_CYCLES = 2'h2;
    localparam int unsigned TCS_CLK_PERIOD_NS = 100;
    localparam int unsigned TCS_SYNC_STAGES = 3;
    typedef logic [TCS_DATA_W-1:0] tcs_byte_t;
    typedef logic [TCS_RATIO_W-1:0] tcs_ratio_t;
endpackage

//--- verilog/tcs_pin_sync.sv
/*
 * Three-stage synchroniser for the external count pin with a two-out-of-
 * two agreement filter on the last two stages.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ps
module tcs_pin_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin_async,
    output logic pin_level
);
    import tcs_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } tcs_sync_s;

    tcs_sync_s st_q;
    tcs_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Only the later stages vote, so a metastable first stage never leaks
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_level = st_q.level;
endmodule // tcs_pin_sync

//--- verilog/tcs_prescaler.sv
/*
 * The shared prescaler counter: counts enabled steps, clears on request.
 * Its value leaves only toward the owning block, never toward software.
 * Assumes clear and step come from logic on the same clock.
 */
`timescale 1ns/1ps
module tcs_prescaler #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic step,
    output logic [WIDTH-1:0] count
);
    import tcs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } tcs_presc_s;

    tcs_presc_s st_q;
    tcs_presc_s st_d;

    always_comb begin
        st_d = st_q;
        // Clear beats a step in the same cycle so the count restarts at zero
        if (clear) begin
            st_d.cnt = '0;
        end else if (step) begin
            st_d.cnt = st_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0; // R11
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
endmodule // tcs_prescaler

//--- verilog/tcs_timer.sv
/*
 * Eight-bit timer/counter with a prescaler shared with the watchdog.
 * Holds the option register, the count register, phase generation,
 * source selection, sampling at the second and fourth phase, write
 * inhibit, prescaler ownership and the pin direction override.
 * Assumes the watchdog outside supplies a one-cycle tick on clk and a
 * one-cycle clear-instruction strobe, and consumes the scaled timeout.
 */
// Design decision made here: the plain strobed port.
//
// Contract
// R01 - Source select clear: count once per instruction cycle without prescaler.
// R02 - After a software count write, skip the next two increments.
// R03 - Source select set: count edges of the external pin.
// R04 - Edge select clear picks rising edge, set picks falling edge.
// R05 - Prescaler belongs to counter or watchdog, never both.
// R06 - Ratio field with assign bit sets division, 1:2 to 1:256 for counter.
// R07 - Counter division is two to the power of ratio plus one.
// R08 - Software can neither read nor load the prescaler count.
// R09 - Count writes clear the prescaler while the counter owns it.
// R10 - Watchdog clear clears the prescaler while the watchdog owns it.
// R11 - Any reset zeroes the prescaler.
// R12 - Prescaler output is sampled at second and fourth phase clocks.
// R13 - Source holds pin high at least two oscillator periods plus margin.
// R14 - With prescaler, pin period at least four periods plus margin over ratio.
// R15 - Counter advances only after the sampled edge is recognised.
// R16 - External source forces the shared pin to input direction.
// R17 - Count register at address one, read and write.
// R18 - Counter to watchdog switch needs watchdog clear, count clear, then option.
// R19 - Watchdog to counter switch needs watchdog clear before option write.
`timescale 1ns/1ps
module tcs_timer #(
    parameter int unsigned PRESC_WIDTH = tcs_pkg::TCS_PRESC_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [tcs_pkg::TCS_ADDR_W-1:0] reg_addr,
    input wire logic [tcs_pkg::TCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tcs_pkg::TCS_DATA_W-1:0] reg_rdata,
    input wire logic external_count_input,
    input wire logic port_direction_control,
    output logic shared_port_pin_dir,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_tick,
    output logic watchdog_timeout,
    output logic watchdog_prescaler_clear,
    output logic [1:0] phase
);
    import tcs_pkg::*;

    // The ratio field indexes up to bit seven of the prescaler
    if (PRESC_WIDTH < 8) begin : g_width_check
        $error("tcs_timer: PRESC_WIDTH must be at least 8");
    end

    typedef struct packed {
        logic [1:0] phase;
        tcs_byte_t option;
        tcs_byte_t count;
        logic [1:0] inhibit;
        logic pin_prev;
        logic sample;
        tcs_byte_t rdata;
        logic wdt_out;
        logic wdt_clr;
    } tcs_timer_s;

    tcs_timer_s st_q;
    tcs_timer_s st_d;

    logic pin_level;
    logic [PRESC_WIDTH-1:0] presc_count;
    logic presc_clear;
    logic presc_step;

    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    tcs_ratio_t prescale_ratio_field;
    logic q2;
    logic q4;
    logic wr_count;
    logic wr_option;
    logic pin_edge;
    logic src_event;
    logic presc_out;
    logic sample_rise;
    logic count_step;
    logic [PRESC_WIDTH-1:0] wdt_mask;

    tcs_pin_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_async(external_count_input),
        .pin_level(pin_level)
    );

    tcs_prescaler #(
        .WIDTH(PRESC_WIDTH)
    ) u_presc (
        .clk(clk),
        .rst_b(rst_b),
        .clear(presc_clear),
        .step(presc_step),
        .count(presc_count)
    );

    assign clock_source_select = st_q.option[TCS_BIT_CLOCK_SOURCE];
    assign source_edge_select = st_q.option[TCS_BIT_SOURCE_EDGE];
    assign prescaler_assign = st_q.option[TCS_BIT_PRESCALER_ASSIGN];
    assign prescale_ratio_field = st_q.option[TCS_RATIO_LSB +: TCS_RATIO_W];
    assign q2 = (st_q.phase == TCS_PHASE_Q2);
    assign q4 = (st_q.phase == TCS_PHASE_Q4);
    assign wr_count = reg_wr && (reg_addr == TCS_OFF_COUNT);
    assign wr_option = reg_wr && (reg_addr == TCS_OFF_OPTION);

    // Edge of the pin in the chosen polarity; XOR folds the falling case in
    assign pin_edge = (pin_level ^ source_edge_select) &&
        !(st_q.pin_prev ^ source_edge_select); // R04

    always_comb begin
        if (clock_source_select) begin
            src_event = pin_edge; // R03
        end else begin
            src_event = q4; // R01
        end
    end

    // Prescaler ownership: either the count source or the watchdog tick steps it
    always_comb begin
        if (prescaler_assign) begin
            presc_step = watchdog_tick; // R05
            presc_clear = watchdog_clear_instruction; // R10
        end else begin
            presc_step = src_event; // R05 R14
            presc_clear = wr_count; // R09
        end
    end

    // Bit k of the counter has period 2^(k+1) source events
    always_comb begin
        if (prescaler_assign) begin
            if (clock_source_select) begin
                presc_out = pin_level ^ source_edge_select; // R12
            end else begin
                presc_out = 1'b0;
            end
        end else begin
            presc_out = presc_count[prescale_ratio_field]; // R06 R07
        end
    end

    // Watchdog postscale mask: ratio k passes one tick in 2^k
    always_comb begin
        wdt_mask = '0;
        for (int i = 0; i < TCS_RATIO_W + 4; i++) begin
            if (i < PRESC_WIDTH && i < int'(prescale_ratio_field)) begin
                wdt_mask[i] = 1'b1;
            end
        end
    end

    assign sample_rise = (q2 || q4) && presc_out && !st_q.sample; // R15

    always_comb begin
        if (!clock_source_select && prescaler_assign) begin
            count_step = q4; // R01
        end else begin
            count_step = sample_rise; // R15
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.phase = st_q.phase + 2'h1;
        st_d.pin_prev = pin_level;
        // Sampling only at the second and fourth phase mimics the quadrature clocks
        if (q2 || q4) begin
            st_d.sample = presc_out; // R12
        end
        if (wr_option) begin
            st_d.option = reg_wdata;
        end
        if (wr_count) begin
            st_d.count = reg_wdata; // R17
            st_d.inhibit = TCS_WRITE_INHIBIT_CYCLES; // R02
        end else if (count_step) begin
            // Inhibit swallows whole increments, so a written value holds
            if (st_q.inhibit != 2'h0) begin
                st_d.inhibit = st_q.inhibit - 2'h1; // R02
            end else begin
                st_d.count = st_q.count + 8'h01;
            end
        end
        st_d.rdata = '0;
        if (reg_rd && reg_addr == TCS_OFF_COUNT) begin
            st_d.rdata = st_q.count; // R17 R08
        end
        if (prescaler_assign) begin
            st_d.wdt_out = watchdog_tick &&
                ((presc_count & wdt_mask) == wdt_mask); // R05 R06
        end else begin
            st_d.wdt_out = watchdog_tick; // R05
        end
        st_d.wdt_clr = watchdog_clear_instruction && prescaler_assign; // R10
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.option <= TCS_OPTION_RESET;
            st_q.count <= TCS_COUNT_RESET;
            // Matches the sampled level of a low pin under the reset option, so no false count
            st_q.sample <= TCS_OPTION_RESET[TCS_BIT_SOURCE_EDGE];
        end else begin
            st_q <= st_d;
        end
    end

    // Forced input while the pin is the count source
    assign shared_port_pin_dir = clock_source_select | port_direction_control; // R16
    assign reg_rdata = st_q.rdata;
    assign watchdog_timeout = st_q.wdt_out;
    assign watchdog_prescaler_clear = st_q.wdt_clr;
    assign phase = st_q.phase;
endmodule // tcs_timer

//--- testbench/tcs_timer_sva.sv
/* Port checker for tcs_timer: bus answers, phase, pin direction, watchdog strobes.
   Assumes tcs_pkg is compiled first; bound into every tcs_timer. */
`timescale 1ns/1ps
module tcs_timer_sva #(
    parameter int unsigned PRESC_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [tcs_pkg::TCS_ADDR_W-1:0] reg_addr,
    input wire logic [tcs_pkg::TCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tcs_pkg::TCS_DATA_W-1:0] reg_rdata,
    input wire logic port_direction_control,
    input wire logic shared_port_pin_dir,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_tick,
    input wire logic watchdog_timeout,
    input wire logic watchdog_prescaler_clear,
    input wire logic [1:0] phase
);
    import tcs_pkg::*;
    logic wd_owns_q;
    logic opt_wr;
    assign opt_wr = reg_wr && reg_addr == TCS_OFF_OPTION;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_owns_q <= TCS_OPTION_RESET[TCS_BIT_PRESCALER_ASSIGN];
        end else if (opt_wr) begin
            wd_owns_q <= reg_wdata[TCS_BIT_PRESCALER_ASSIGN];
        end
    end
    // Mirror of the prescaler while the watchdog owns it; valid from reset and after each clear
    logic [7:0] wd_cnt_q;
    tcs_ratio_t wd_ratio_q;
    logic wd_known_q;
    logic [7:0] wd_mask;
    assign wd_mask = (8'h01 << wd_ratio_q) - 8'h01;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_cnt_q <= 8'h00;
            wd_ratio_q <= TCS_OPTION_RESET[TCS_RATIO_LSB +: TCS_RATIO_W];
            wd_known_q <= 1'b1;
        end else begin
            if (opt_wr) begin
                wd_ratio_q <= reg_wdata[TCS_RATIO_LSB +: TCS_RATIO_W];
            end
            if (opt_wr && !reg_wdata[TCS_BIT_PRESCALER_ASSIGN]) begin
                wd_known_q <= 1'b0;
            end else if (wd_owns_q && watchdog_clear_instruction) begin
                wd_known_q <= 1'b1;
            end
            if (wd_owns_q && watchdog_clear_instruction) begin
                wd_cnt_q <= 8'h00;
            end else if (wd_owns_q && watchdog_tick) begin
                wd_cnt_q <= wd_cnt_q + 8'h01;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_phase_step: assert property ($past(rst_b) |-> phase == $past(phase) + 2'h1)
        else $error("phase did not advance");
    chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    chk_hidden_rd: assert property (reg_rd && reg_addr != TCS_OFF_COUNT |=> reg_rdata == 8'h00)
        else $error("hidden address returned data");
    chk_wr_rd_back: assert property (reg_wr && reg_addr == TCS_OFF_COUNT ##1
        reg_rd && reg_addr == TCS_OFF_COUNT |=> reg_rdata == $past(reg_wdata, 2))
        else $error("count lost the written value");
    chk_pin_input: assert property (opt_wr && reg_wdata[TCS_BIT_CLOCK_SOURCE] |=> shared_port_pin_dir)
        else $error("pin not forced to input");
    chk_dir_free: assert property (opt_wr && !reg_wdata[TCS_BIT_CLOCK_SOURCE] ##1
        !port_direction_control |-> !shared_port_pin_dir)
        else $error("pin direction ignores its control");
    chk_tick_direct: assert property (!opt_wr && !wd_owns_q && watchdog_tick |=> watchdog_timeout)
        else $error("undivided tick gave no timeout");
    chk_tick_only: assert property (!watchdog_tick |=> !watchdog_timeout)
        else $error("timeout without tick");
    chk_clr_owner: assert property (!opt_wr && watchdog_clear_instruction && wd_owns_q
        |=> watchdog_prescaler_clear)
        else $error("clear missed while watchdog owns");
    chk_clr_blocked: assert property (!opt_wr && watchdog_clear_instruction && !wd_owns_q
        |=> !watchdog_prescaler_clear)
        else $error("clear while counter owns");
    chk_wd_divide: assert property (wd_known_q && wd_owns_q && watchdog_tick
        && (wd_cnt_q & wd_mask) == wd_mask |=> watchdog_timeout)
        else $error("postscaled tick gave no timeout");
    chk_wd_hold: assert property (wd_known_q && wd_owns_q && (wd_cnt_q & wd_mask) != wd_mask
        |=> !watchdog_timeout)
        else $error("timeout before postscale count");
    cov_ext_mode: cover property (opt_wr && reg_wdata[TCS_BIT_CLOCK_SOURCE]);
    cov_wd_div: cover property (wd_known_q && wd_owns_q && wd_ratio_q == 3'h3 && watchdog_timeout);
    cov_timeout: cover property (watchdog_timeout && wd_owns_q);
    cov_psc_clear: cover property (watchdog_prescaler_clear);
endmodule // tcs_timer_sva

bind tcs_timer tcs_timer_sva #(.PRESC_WIDTH(PRESC_WIDTH)) i_sva (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_direction_control(port_direction_control),
    .shared_port_pin_dir(shared_port_pin_dir),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .watchdog_tick(watchdog_tick), .watchdog_timeout(watchdog_timeout),
    .watchdog_prescaler_clear(watchdog_prescaler_clear), .phase(phase)
);

//--- testbench/tcs_pin_model.sv
/* External count source: square wave on the count pin while enabled.
   Assumes the bench keeps each level longer than the sampling minimum. */
`timescale 1ns/1ps
module tcs_pin_model (
    input wire logic run,
    input wire logic [15:0] half_ns,
    output logic pin
);
    // When stopped, finishes the pending half period and then holds its level, so stopping adds no edge of its own
    initial begin
        pin = 1'b0;
        forever begin
            wait (run);
            #(half_ns);
            pin = ~pin;
        end
    end
endmodule // tcs_pin_model

//--- testbench/tcs_timer_tb_top.sv
/* Self-checking bench for tcs_timer: modes, ratios, count writes, pin direction.
   Assumes tcs_pkg, the design, tcs_pin_model and the bound checker. */
`timescale 1ns/1ps
module tcs_timer_tb_top;
    import tcs_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic pdc = 1'b0, wd_clr = 1'b0, wd_tick = 1'b0, ext, dir, run = 1'b0, clr_req = 1'b0;
    tcs_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_n;
    logic [15:0] half_ns = 16'h012c;
    logic [1:0] phase, ph_n;
    logic [31:0] s = 32'hd5f4b22c;
    int n_errors = 0, n_compared = 0, steps, n_rise, n_fall;
    always #50 clk = ~clk;
    always @(negedge clk) begin
        ph_n = phase;
        rd_n = reg_rdata;
    end
    always @(posedge ext) n_rise++;
    always @(negedge ext) n_fall++;
    tcs_timer #(.PRESC_WIDTH(TCS_PRESC_W)) i_dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_input(ext), .port_direction_control(pdc),
        .shared_port_pin_dir(dir), .watchdog_clear_instruction(wd_clr),
        .watchdog_tick(wd_tick), .watchdog_timeout(), .watchdog_prescaler_clear(),
        .phase(phase)
    );
    tcs_pin_model i_pin (.run(run), .half_ns(half_ns), .pin(ext));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    // Two count steps after a write are swallowed
    function automatic tcs_byte_t exp_cnt(tcs_byte_t v, int e, logic psc, tcs_ratio_t k);
        int r;
        r = psc ? (e + (1 << k)) >> (k + 1) : e;
        return v + tcs_byte_t'((r > 2) ? r - 2 : 0);
    endfunction
    task automatic tick();
        @(posedge clk);
        if (ph_n === 2'h3) steps++;
        s = xs(s);
        wd_tick <= s[0] & s[1];
        wd_clr <= clr_req | (&s[4:2]);
    endtask
    task automatic wr(input tcs_byte_t a, input tcs_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick();
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input tcs_byte_t a, output tcs_byte_t d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        reg_rd <= 1'b0;
        tick();
        d = rd_n;
    endtask
    task automatic chk(input tcs_byte_t got, input tcs_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        n_errors++;
        stop_test();
    end
    initial begin
        tcs_byte_t o, v, got;
        tcs_byte_t tbl [5] = '{8'h0f, 8'h07, 8'h28, 8'h38, 8'h30};
        int n;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        tick();
        chk({7'h0, dir}, {7'h0, TCS_OPTION_RESET[TCS_BIT_CLOCK_SOURCE]});
        for (int i = 0; i < 16; i++) begin
            s = xs(s);
            o = (i < 5) ? tbl[i] : s[7:0];
            v = s[15:8];
            n = (i < 5) ? 3000 : 40 + s[25:16] % 600;
            pdc <= s[26];
            half_ns <= 16'h012c + {7'h0, s[24:16]};
            clr_req = 1'b1;
            tick();
            clr_req = 1'b0;
            tick();
            wr(TCS_OFF_COUNT, 8'h00);
            tick();
            wr(TCS_OFF_OPTION, o);
            repeat (12) tick();
            chk({7'h0, dir}, {7'h0, o[TCS_BIT_CLOCK_SOURCE] | pdc});
            wr(TCS_OFF_COUNT, v);
            steps = 0;
            n_rise = 0;
            n_fall = 0;
            rd(TCS_OFF_COUNT, got);
            chk(got, v);
            run <= 1'b1;
            repeat (n) tick();
            run <= 1'b0;
            repeat (16) tick();
            while (ph_n !== 2'h2) tick();
            v = exp_cnt(v, o[5] ? (o[4] ? n_fall : n_rise) : steps, !o[3], o[2:0]);
            rd(TCS_OFF_COUNT, got);
            chk(got, v);
            rd((i < 2 || s[23:16] == TCS_OFF_COUNT) ? TCS_OFF_OPTION : s[23:16], got);
            chk(got, 8'h00);
        end
        pdc <= 1'b0;
        rst_b <= 1'b0;
        tick();
        rst_b <= 1'b1;
        tick();
        chk({7'h0, dir}, 8'h01);
        repeat (8) tick();
        rd(TCS_OFF_COUNT, got);
        chk(got, TCS_COUNT_RESET);
        stop_test();
    end
endmodule // tcs_timer_tb_top
